// *** rtl/rx_line_defs.svh ***
/*
 * Constants of the receive recovery, decode and loss-detect channel.
 * Assumes a 100 MHz system clock; included by the package and the top.
 */
`ifndef RX_LINE_DEFS_SVH
`define RX_LINE_DEFS_SVH

// ****************************************************************
// rates
// ****************************************************************
`define SYS_CLK_KHZ 100000
`define DPLL_T1_KHZ 24704
`define DPLL_E1_KHZ 32768
`define NCO_W 24
`define PHASE_W 4
`define PHASE_ALIGN 4'h2
`define PHASE_MID 4'h8
`define PHASE_LAST 4'hF
`define MCLK_HELD_CYC 9'h100

// ****************************************************************
// line decoder
// ****************************************************************
`define DEC_DEPTH 8
`define DEC_HALF 4
`define B8ZS_MARKS 8'h1B
`define B8ZS_VIOLS 8'h12
`define HDB3_VIOLS 4'h1
`define HDB3_MARKS_A 4'h1
`define HDB3_MARKS_B 4'h9

// ****************************************************************
// loss of signal
// ****************************************************************
`define ZRUN_W 12
`define LOS_T1_ZEROS 12'h0AF
`define LOS_E1_ZEROS 12'h020
`define LOS_E1ALT_ZEROS 12'h800
`define CLR_T1_ZMAX 12'h063
`define CLR_E1_ZMAX 12'h00F
`define CLR_T1_MARKS 8'h10
`define CLR_E1_MARKS 8'h04
`define WIN_T1_BITS 8'h80
`define WIN_E1_BITS 8'h20
`define WIN_T1_TAP 127
`define WIN_E1_TAP 31
`define LOS_WIN_BITS 128
`define FIFO_WORDS 4

`endif

// *** rtl/rx_line_pkg.sv ***
/*
 * Types of the receive channel: loss states and the state record.
 * Assumes the constants header is on the include path.
 */
`include "rx_line_defs.svh"

package rx_line_pkg;

    // one-hot loss-of-signal states
    typedef enum logic [1:0] {
        LOS_IDLE = 2'h1,
        LOS_ALARM = 2'h2
    } los_state_t;

    // whole state of the channel top
    typedef struct packed {
        logic pos_m, pos_s, neg_m, neg_s, mclk_m, mclk_s;
        logic rule_m, rule_s, edge_polarity_select_m, edge_polarity_select_s;
        logic [8:0] mclk_cnt;
        logic [`NCO_W-1:0] nco;
        logic [`PHASE_W-1:0] phase;
        logic lvl, edge_p, seen_p, seen_n;
        logic pend_v, pend_p, pend_n;
        logic last_pol, had_mark;
        logic [`DEC_DEPTH-1:0] mh, vh;
        logic [`ZRUN_W-1:0] zrun;
        logic [`LOS_WIN_BITS-1:0] win;
        logic [7:0] mcnt, since;
        los_state_t los;
        logic pos_o, neg_o, sgl_o, clk_o, viol_o;
        logic los_o, irq_o, term_o;
    } rx_state_t;

endpackage

// *** rtl/rx_bit_fifo.sv ***
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes DEPTH is a power of two and one clock for both sides.
 */
`timescale 1ns/100ps

module rx_bit_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys, // system clock
    input wire logic srst, // synchronous reset
    input wire logic [WIDTH-1:0] in_data, // word to store
    input wire logic in_valid, // in_data is offered
    output logic in_ready, // room for a word
    output logic [WIDTH-1:0] out_data, // oldest word
    output logic out_valid, // a word is held
    input wire logic out_ready // drain side takes it
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wr;
        logic [AW:0] rd;
    } fifo_state_t;

    fifo_state_t f_q, f_d;

    // extra pointer bit tells full from empty
    assign in_ready = !((f_q.wr[AW] != f_q.rd[AW]) &&
                        (f_q.wr[AW-1:0] == f_q.rd[AW-1:0]));
    assign out_valid = (f_q.wr != f_q.rd);
    assign out_data = f_q.mem[f_q.rd[AW-1:0]];

    // push and pop may share a cycle
    always_comb begin
        f_d = f_q;
        if (in_valid && in_ready) begin
            f_d.mem[f_q.wr[AW-1:0]] = in_data;
            f_d.wr = f_q.wr + 1'b1;
        end
        if (out_valid && out_ready) begin
            f_d.rd = f_q.rd + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            f_q <= '0;
        end else begin
            f_q <= f_d;
        end
    end
endmodule

// *** rtl/rx_line_recovery.sv ***
/*
 * One receive channel: oversampling clock/data recovery or raw slice
 * pass-through, AMI / B8ZS / HDB3 decoding, loss-of-signal detection
 * and all-ones fill. Assumes slicer pulses, the master clock, the rule
 * pin and the edge pin arrive asynchronously; the other inputs are
 * configuration bits on the system clock.
 */
// Behaviour
// - recovery loop ticks at sixteen times line rate, T1 or E1.
// - recovery bit 0 gives recovered clock and retimed NRZ data.
// - recovery bit 1 passes raw slices; clock out is their XOR.
// - master clock held high forces raw slicing, ignoring recovery bit.
// - jitter buffer sits before decoding; single rail decoded, dual undecoded.
// - global bit or rule pin picks B8ZS/HDB3 or AMI for all.
// - override bit makes this channel use its own rule bit.
// - dual rail bypasses the decoder and ignores every line-code rule input.
// - loss output high during loss; status output tracks it.
// - pulse interrupt on loss set and on clear unless masked.
// - loss after 175, 32 or 2048 consecutive zeros.
// - T1 clears with 16 marks per 128 bits, runs at most 99.
// - E1 clears with 4 marks per 32 bits, runs at most 15.
// - hardware mode allows only the T1 and first E1 rule.
// - during loss, fill enable chooses sliced data or all ones.
// - during loss with fill enabled, clock out carries master clock.
// - single-ended termination only in host mode, bit set.
// - single rail flags each code violation on violation output.
// - edge select high: unpaced data moves on rising clock edge, else falling; paced data moves on the other edge.
`timescale 1ns/100ps
`include "rx_line_defs.svh"

module rx_line_recovery
    import rx_line_pkg::*;
(
    input wire logic clk_sys, // 100 MHz system clock
    input wire logic srst, // synchronous reset, high
    input wire logic slice_pos_in, // positive slicer pulse, pin
    input wire logic slice_neg_in, // negative slicer pulse, pin
    input wire logic master_clk_in, // master reference clock, pin
    input wire logic global_rule_pin, // rule-select pin, high = AMI
    input wire logic edge_polarity_select, // edge select pin
    input wire logic t1_mode, // 1 = T1, 0 = E1
    input wire logic host_mode, // 1 = host, 0 = hardware mode
    input wire logic single_rail_mode, // 1 = single rail
    input wire logic chan_recovery_mode_bit, // 1 = raw slicing
    input wire logic global_config_ami, // global rule bit, 1 = AMI
    input wire logic chan_rule_override_bit, // use own rule bit
    input wire logic chan_line_rule_bit, // own rule, 1 = AMI
    input wire logic e1_alt_los_rule, // host: alternative E1 rule
    input wire logic alarm_fill_enable, // all-ones fill in loss
    input wire logic los_irq_mask, // 1 masks loss interrupt
    input wire logic jitter_atten_en, // pace data through buffer
    input wire logic single_end_term_bit, // termination mode bit
    output logic rx_pos_rail_out, // positive rail data
    output logic rx_neg_rail_out, // negative rail data
    output logic rx_single_rail_out, // decoded single rail data
    output logic rx_recovered_clock_out, // recovered clock
    output logic violation_flag_out, // code violation flag
    output logic loss_alarm_out, // loss of signal
    output logic loss_status_out, // loss status bit
    output logic los_irq_out, // loss change interrupt pulse
    output logic term_single_end_out // single-ended termination
);

    // ****************************************************************
    // constants and decode
    // ****************************************************************
    localparam logic [`NCO_W-1:0] INC_T1 = `NCO_W'(
        (64'(`DPLL_T1_KHZ) << `NCO_W) / 64'(`SYS_CLK_KHZ));
    localparam logic [`NCO_W-1:0] INC_E1 = `NCO_W'(
        (64'(`DPLL_E1_KHZ) << `NCO_W) / 64'(`SYS_CLK_KHZ));

    rx_state_t s_q, s_d;
    logic mclk_held, bypass, use_ami, alt_e1, pop, drain_ready, ais;
    logic tick, emit, line_mark, bv, f_valid, f_in_ready;
    logic [1:0] f_data;
    logic [`PHASE_W-1:0] incr;
    logic [`ZRUN_W-1:0] thr, zmax, zrun_n;
    logic [7:0] need, winlen;
    logic [`DEC_DEPTH-1:0] mh_n, vh_n;

    // pick a T1 or E1 figure; used for the zero-run limits thr and zmax
    function automatic logic [`ZRUN_W-1:0] by_rate(
        input logic t1, input logic [`ZRUN_W-1:0] t1v,
        input logic [`ZRUN_W-1:0] e1v);
        by_rate = t1 ? t1v : e1v;
    endfunction

    // marks among the newest bits of the window, 128 for T1, 32 for E1
    function automatic logic [7:0] marks_in(
        input logic [`LOS_WIN_BITS-1:0] w, input logic t1);
        logic [7:0] n;
        n = 8'h00;
        for (int i = 0; i < `LOS_WIN_BITS; i++) begin
            if (t1 || i <= `WIN_E1_TAP) begin
                n = n + {7'h00, w[i]};
            end
        end
        marks_in = n;
    endfunction

    assign mclk_held = (s_q.mclk_cnt == `MCLK_HELD_CYC);
    assign bypass = mclk_held | chan_recovery_mode_bit;
    // per-channel override wins over bit and pin
    assign use_ami = chan_rule_override_bit ? chan_line_rule_bit
                   : (global_config_ami | s_q.rule_s);
    assign alt_e1 = host_mode & e1_alt_los_rule;
    assign thr = by_rate(t1_mode, `LOS_T1_ZEROS,
                         alt_e1 ? `LOS_E1ALT_ZEROS : `LOS_E1_ZEROS);
    assign zmax = by_rate(t1_mode, `CLR_T1_ZMAX, `CLR_E1_ZMAX);
    assign need = t1_mode ? `CLR_T1_MARKS : `CLR_E1_MARKS;
    assign winlen = t1_mode ? `WIN_T1_BITS : `WIN_E1_BITS;
    assign ais = (s_q.los == LOS_ALARM) & alarm_fill_enable;
    // with the buffer paced, bits leave at mid-bit, not on arrival
    assign drain_ready = !jitter_atten_en ||
                         (tick && s_q.phase == `PHASE_MID);
    assign pop = f_valid & drain_ready;

    // ****************************************************************
    // bit buffer between recovery and decoder
    // ****************************************************************
    rx_bit_fifo #(
        .WIDTH(2),
        .DEPTH(`FIFO_WORDS)
    ) u_fifo (
        .clk_sys(clk_sys),
        .srst(srst),
        .in_data({s_q.pend_p, s_q.pend_n}),
        .in_valid(s_q.pend_v),
        .in_ready(f_in_ready),
        .out_data(f_data),
        .out_valid(f_valid),
        .out_ready(drain_ready)
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        incr = 4'h1;
        emit = 1'b0;
        bv = 1'b0;
        line_mark = f_data[1] | f_data[0];
        mh_n = s_q.mh;
        vh_n = s_q.vh;
        zrun_n = s_q.zrun;

        // two-flop synchronisers on every pin
        s_d.pos_m = slice_pos_in;
        s_d.pos_s = s_q.pos_m;
        s_d.neg_m = slice_neg_in;
        s_d.neg_s = s_q.neg_m;
        s_d.mclk_m = master_clk_in;
        s_d.mclk_s = s_q.mclk_m;
        s_d.rule_m = global_rule_pin;
        s_d.rule_s = s_q.rule_m;
        s_d.edge_polarity_select_m = edge_polarity_select;
        s_d.edge_polarity_select_s = s_q.edge_polarity_select_m;

        // a running master clock never stays high this long
        if (!s_q.mclk_s) begin
            s_d.mclk_cnt = '0;
        end else if (!mclk_held) begin
            s_d.mclk_cnt = s_q.mclk_cnt + 9'h001;
        end

        // oversampling tick from a phase accumulator
        {tick, s_d.nco} = {1'b0, s_q.nco} +
                          {1'b0, t1_mode ? INC_T1 : INC_E1};

        // phase steers toward the pulse edge one step on the first tick after each edge
        if (tick) begin
            if (s_q.edge_p) begin
                s_d.edge_p = 1'b0;
                if (s_q.phase < `PHASE_ALIGN) begin
                    incr = 4'h2;
                end else if (s_q.phase > `PHASE_ALIGN) begin
                    incr = 4'h0;
                end
            end
            s_d.phase = s_q.phase + incr;
            emit = (s_q.phase == `PHASE_LAST) && (incr != 4'h0);
        end
        s_d.lvl = s_q.pos_s | s_q.neg_s;
        if (s_d.lvl && !s_q.lvl) begin
            s_d.edge_p = 1'b1;
        end

        // a bit that the buffer refuses waits; a newer one replaces it
        s_d.seen_p = emit ? s_q.pos_s : (s_q.seen_p | s_q.pos_s);
        s_d.seen_n = emit ? s_q.neg_s : (s_q.seen_n | s_q.neg_s);
        if (emit) begin
            s_d.pend_v = 1'b1;
            s_d.pend_p = s_q.seen_p | s_q.pos_s;
            s_d.pend_n = s_q.seen_n | s_q.neg_s;
        end else if (s_q.pend_v && f_in_ready) begin
            s_d.pend_v = 1'b0;
        end

        // recovered clock; unpaced data moves on the chosen edge at phase 0, paced data on the other edge at phase 8
        s_d.clk_o = s_q.edge_polarity_select_s ? !s_q.phase[`PHASE_W-1]
                               : s_q.phase[`PHASE_W-1];
        if (ais) begin
            s_d.clk_o = s_q.mclk_s;
        end

        if (pop) begin
            // decoder: same polarity as last mark is a violation
            bv = line_mark & s_q.had_mark &
                 (f_data[1] == s_q.last_pol);
            if (line_mark) begin
                s_d.last_pol = f_data[1];
                s_d.had_mark = 1'b1;
            end
            mh_n = {s_q.mh[`DEC_DEPTH-2:0], line_mark};
            vh_n = {s_q.vh[`DEC_DEPTH-2:0], bv};
            // substitutions become zeros before they leave the line
            if (!use_ami) begin
                if (t1_mode && mh_n == `B8ZS_MARKS &&
                    vh_n == `B8ZS_VIOLS) begin
                    mh_n = '0;
                    vh_n = '0;
                end else if (!t1_mode &&
                    vh_n[`DEC_HALF-1:0] == `HDB3_VIOLS &&
                    (mh_n[`DEC_HALF-1:0] == `HDB3_MARKS_A ||
                     mh_n[`DEC_HALF-1:0] == `HDB3_MARKS_B)) begin
                    mh_n[`DEC_HALF-1:0] = '0;
                    vh_n[`DEC_HALF-1:0] = '0;
                end
            end
            s_d.mh = mh_n;
            s_d.vh = vh_n;

            // loss: consecutive zeros, saturating
            if (line_mark) begin
                zrun_n = '0;
            end else if (s_q.zrun >= thr) begin
                zrun_n = thr;
            end else begin
                zrun_n = s_q.zrun + 12'h001;
            end
            s_d.zrun = zrun_n;
            // sliding window of marks; the count is taken afresh each bit
            // so a T1/E1 switch cannot leave it out of step (no underflow)
            s_d.win = {s_q.win[`LOS_WIN_BITS-2:0], line_mark};
            s_d.mcnt = marks_in(s_d.win, t1_mode);
            // bits since the last too-long zero run
            if (zrun_n > zmax) begin
                s_d.since = '0;
            end else if (s_q.since < winlen) begin
                s_d.since = s_q.since + 8'h01;
            end
            unique case (s_q.los)
                LOS_IDLE: begin
                    if (zrun_n == thr) begin
                        s_d.los = LOS_ALARM;
                    end
                end
                LOS_ALARM: begin
                    if (s_d.mcnt >= need && s_d.since >= winlen) begin
                        s_d.los = LOS_IDLE;
                    end
                end
                default: begin
                    s_d.los = LOS_IDLE;
                end
            endcase

            // output data: fill, decoded single rail, or dual NRZ
            if (ais) begin
                s_d.pos_o = 1'b1;
                s_d.neg_o = 1'b1;
                s_d.sgl_o = 1'b1;
                s_d.viol_o = 1'b0;
            end else if (single_rail_mode) begin
                s_d.pos_o = 1'b0;
                s_d.neg_o = 1'b0;
                s_d.sgl_o = s_q.mh[`DEC_DEPTH-1];
                s_d.viol_o = s_q.vh[`DEC_DEPTH-1];
            end else begin
                s_d.pos_o = f_data[1];
                s_d.neg_o = f_data[0];
                s_d.sgl_o = 1'b0;
                s_d.viol_o = 1'b0;
            end
        end
        if (!single_rail_mode) begin
            s_d.viol_o = 1'b0;
        end

        // raw slicing: no retiming, no loss, active level from pin
        if (bypass) begin
            s_d.pos_o = s_q.edge_polarity_select_s ? s_q.pos_s : !s_q.pos_s;
            s_d.neg_o = s_q.edge_polarity_select_s ? s_q.neg_s : !s_q.neg_s;
            s_d.clk_o = s_q.pos_s ^ s_q.neg_s;
            s_d.sgl_o = 1'b0;
            s_d.viol_o = 1'b0;
            s_d.los = LOS_IDLE;
            s_d.zrun = '0;
        end

        s_d.los_o = (s_d.los == LOS_ALARM);
        s_d.irq_o = (s_d.los != s_q.los) && !los_irq_mask;
        s_d.term_o = host_mode & single_end_term_bit;
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_q <= '0;
            s_q.los <= LOS_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign rx_pos_rail_out = s_q.pos_o;
    assign rx_neg_rail_out = s_q.neg_o;
    assign rx_single_rail_out = s_q.sgl_o;
    assign rx_recovered_clock_out = s_q.clk_o;
    assign violation_flag_out = s_q.viol_o;
    assign loss_alarm_out = s_q.los_o;
    assign loss_status_out = s_q.los_o;
    assign los_irq_out = s_q.irq_o;
    assign term_single_end_out = s_q.term_o;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    sequence s_last_zero;
        !bypass && pop && !line_mark && s_q.los == LOS_IDLE;
    endsequence
    sequence s_run_full;
        s_last_zero ##0 (s_q.zrun == thr - 12'h001);
    endsequence

    property p_bypass_clk;
        chan_recovery_mode_bit |=> rx_recovered_clock_out ==
            ($past(s_q.pos_s) ^ $past(s_q.neg_s));
    endproperty
    a_bypass_clk: assert property (p_bypass_clk)
        else $error("raw clock is not the rail xor");

    property p_mclk_held;
        mclk_held |=> loss_alarm_out == 1'b0 && rx_recovered_clock_out
            == ($past(s_q.pos_s) ^ $past(s_q.neg_s));
    endproperty
    a_mclk_held: assert property (p_mclk_held)
        else $error("held master clock did not force raw slicing");

    property p_retime;
        !bypass && pop && !ais && !single_rail_mode |=>
            rx_pos_rail_out == $past(f_data[1]) &&
            rx_neg_rail_out == $past(f_data[0]);
    endproperty
    a_retime: assert property (p_retime)
        else $error("dual rail data not the recovered bit");

    property p_los_set;
        s_run_full |=> loss_alarm_out && loss_status_out;
    endproperty
    a_los_set: assert property (p_los_set)
        else $error("loss not raised at zero threshold");

    property p_zero_reset;
        !bypass && pop && line_mark |=> s_q.zrun == '0 ##1 s_q.zrun <= 1;
    endproperty
    a_zero_reset: assert property (p_zero_reset)
        else $error("zero counter not cleared by a mark");

    property p_ais_fill;
        !bypass && pop && ais |=> rx_pos_rail_out && rx_neg_rail_out
            && rx_single_rail_out;
    endproperty
    a_ais_fill: assert property (p_ais_fill)
        else $error("fill is not all ones during loss");

    property p_ais_clk;
        !bypass && ais |=> rx_recovered_clock_out == $past(s_q.mclk_s);
    endproperty
    a_ais_clk: assert property (p_ais_clk)
        else $error("clock out not master clock during loss");

    property p_irq;
        $changed(loss_alarm_out) && !$past(los_irq_mask) |-> los_irq_out;
    endproperty
    a_irq: assert property (p_irq)
        else $error("loss change gave no interrupt");

    property p_dual_viol;
        !single_rail_mode |=> !violation_flag_out;
    endproperty
    a_dual_viol: assert property (p_dual_viol)
        else $error("violation flagged in dual rail");

    property p_term;
        !host_mode |=> !term_single_end_out;
    endproperty
    a_term: assert property (p_term)
        else $error("single-ended termination outside host mode");
endmodule

// *** verif/line_slicer_model.sv ***
/*
 * Slicer model: RZ marks of alternating polarity at the line rate.
 * Assumes the 100 MHz system clock; drives on its falling edge.
 */
`timescale 1ns/100ps

module line_slicer_model (
    input wire logic clk_sys, // system clock
    input wire logic t1_mode, // 1 = T1 rate, 0 = E1 rate
    input wire logic send_marks, // 1 = a mark in every bit
    input wire logic same_pol, // 1 = marks keep one polarity
    output logic slice_pos_in = 1'h0, // positive pulse
    output logic slice_neg_in = 1'h0 // negative pulse
);
    int acc = 0;
    int age = 99;
    logic pol = 1'h0;

    // bit timing from a rate accumulator; pulses 8 cycles wide keep the
    // minimum width and gap, and silence leaves both lines low
    always @(negedge clk_sys) begin
        acc = acc + (t1_mode ? 1544 : 2048);
        age = age + 1;
        if (acc >= 100000) begin
            acc = acc - 100000;
            age = 0;
            pol = pol ^ (send_marks && !same_pol); // alternate unless held
        end
        slice_pos_in <= send_marks && pol && age < 8;
        slice_neg_in <= send_marks && !pol && age < 8;
    end
endmodule

// *** verif/t1e1_receive_recovery_decode_los_bench.sv ***
/*
 * Bench of one receive channel: loss set and clear, fill, bypass paths.
 * Assumes the design files and the slicer model are compiled first.
 */
`timescale 1ns/100ps

module t1e1_receive_recovery_decode_los_bench;
    // ****************************************************************
    // signals and design
    // ****************************************************************
    logic clk_sys = 1'h0, srst, master_clk_in = 1'h0, global_rule_pin;
    logic edge_polarity_select, t1_mode, host_mode, single_rail_mode;
    logic chan_recovery_mode_bit, global_config_ami, jitter_atten_en;
    logic chan_rule_override_bit, chan_line_rule_bit, e1_alt_los_rule;
    logic alarm_fill_enable, los_irq_mask, single_end_term_bit;
    logic send_marks, same_pol, mclk_run, slice_pos_in, slice_neg_in;
    logic rx_pos_rail_out, rx_neg_rail_out, rx_single_rail_out;
    logic rx_recovered_clock_out, violation_flag_out, loss_alarm_out;
    logic loss_status_out, los_irq_out, term_single_end_out;
    int num_errors = 0, tests_run = 0, irq_cnt = 0, cyc = 0;

    rx_line_recovery DUT (.*);
    line_slicer_model slicer (.*);

    always #5 clk_sys = ~clk_sys;
    // master clock toggles unless held high to force raw slicing
    always @(negedge clk_sys) begin
        master_clk_in <= mclk_run ? ~master_clk_in : 1'h1;
    end
    // interrupt pulses counted; the ceiling is about twice the run length
    always @(posedge clk_sys) begin
        irq_cnt <= irq_cnt + (los_irq_out === 1'h1);
        cyc <= cyc + 1;
        if (cyc == 70000) begin
            num_errors++;
            finish_test();
        end
    end

    // ****************************************************************
    // tasks
    // ****************************************************************
    task check(input string what, input logic seen, input logic exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %b seen %b", what, exp, seen);
        end
    endtask

    task finish_test();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // marks or silence on the line for n bit periods
    task line(input logic m, input int n);
        send_marks = m;
        repeat (n * 100000 / (t1_mode ? 1544 : 2048)) @(negedge clk_sys);
    endtask

    // raw slices reach the rails; the clock output is their exclusive or
    task check_bypass();
        int k;
        k = 0;
        while (slice_pos_in !== 1'h1 && k < 200) begin
            @(negedge clk_sys);
            k++;
        end
        repeat (5) @(negedge clk_sys);
        check("pos rail", rx_pos_rail_out, 1'h1);
        check("neg rail", rx_neg_rail_out, 1'h0);
        check("clock xor", rx_recovered_clock_out, 1'h1);
        repeat (8) @(negedge clk_sys);
        check("clock low", rx_recovered_clock_out, 1'h0);
    endtask

    // ****************************************************************
    // sequence
    // ****************************************************************
    initial begin
        {global_rule_pin, t1_mode, host_mode} = 3'h0;
        {single_rail_mode, chan_recovery_mode_bit, global_config_ami} = 3'h0;
        {chan_rule_override_bit, chan_line_rule_bit, jitter_atten_en} = 3'h0;
        {alarm_fill_enable, los_irq_mask, single_end_term_bit} = 3'h0;
        {srst, edge_polarity_select, e1_alt_los_rule, mclk_run} = 4'hF;
        {send_marks, same_pol} = 2'h0;
        repeat (6) @(negedge clk_sys);
        srst = 1'h0;
        @(negedge clk_sys);
        check("loss at reset", loss_alarm_out, 1'h0);
        host_mode = 1'h1;
        single_end_term_bit = 1'h1;
        repeat (2) @(negedge clk_sys);
        check("term host", term_single_end_out, 1'h1);
        host_mode = 1'h0;
        repeat (2) @(negedge clk_sys);
        check("term hw", term_single_end_out, 1'h0);
        // hardware mode must ignore the alternative rule bit
        line(1'h0, 28);
        check("e1 early", loss_alarm_out, 1'h0);
        line(1'h0, 10);
        check("e1 loss", loss_alarm_out, 1'h1);
        check("status", loss_status_out, 1'h1);
        check("irq set", irq_cnt == 1, 1'h1);
        alarm_fill_enable = 1'h1;
        single_rail_mode = 1'h1;
        line(1'h0, 12);
        check("fill ones", rx_single_rail_out, 1'h1);
        alarm_fill_enable = 1'h0;
        single_rail_mode = 1'h0;
        // long zero run still inside the window holds the alarm
        line(1'h1, 2);
        check("e1 held", loss_alarm_out, 1'h1);
        line(1'h1, 38);
        check("e1 clear", loss_alarm_out, 1'h0);
        check("irq clear", irq_cnt == 2, 1'h1);
        check("nrz mark", rx_pos_rail_out ^ rx_neg_rail_out, 1'h1);
        los_irq_mask = 1'h1;
        line(1'h0, 40);
        check("masked", irq_cnt == 2 && loss_alarm_out, 1'h1);
        los_irq_mask = 1'h0;
        host_mode = 1'h1;
        line(1'h1, 40);
        line(1'h0, 40);
        check("alt rule", loss_alarm_out, 1'h0);
        host_mode = 1'h0;
        t1_mode = 1'h1;
        // paced buffer for the whole T1 part: bits leave at mid-bit
        jitter_atten_en = 1'h1;
        line(1'h1, 10);
        line(1'h0, 168);
        check("t1 early", loss_alarm_out, 1'h0);
        line(1'h0, 14);
        check("t1 loss", loss_alarm_out, 1'h1);
        line(1'h1, 20);
        check("t1 held", loss_alarm_out, 1'h1);
        line(1'h1, 120);
        check("t1 clear", loss_alarm_out, 1'h0);
        // single rail: alternating marks decode to ones, held polarity
        // makes every mark a bipolar violation
        single_rail_mode = 1'h1;
        line(1'h1, 12);
        check("decoded ones", rx_single_rail_out, 1'h1);
        check("no violation", violation_flag_out, 1'h0);
        check("single pos", rx_pos_rail_out, 1'h0);
        same_pol = 1'h1;
        line(1'h1, 14);
        check("violation", violation_flag_out, 1'h1);
        {same_pol, single_rail_mode} = 2'h0;
        chan_recovery_mode_bit = 1'h1;
        check_bypass();
        chan_recovery_mode_bit = 1'h0;
        mclk_run = 1'h0;
        repeat (300) @(negedge clk_sys);
        check_bypass();
        finish_test();
    end
endmodule
